// ===== hdl/gft_top.sv
// Register access over Avalon-MM was decided locally.
`default_nettype none
// Notes on behaviour
// - Set tab flag when new health over previous health is below threshold.
// - Tab detection runs only while its enable bit is set.
// - In interrupt mode the tab flag drives the serial or enable pin.
// - Short detection runs only while its enable bit is set.
// - Self-discharge current is evaluated once each hour.
// - Short flag sets when current is below minus capacity over hour rate.
// - Each update moves filtered current by a step set by the filter.
// - Short compare waits the configured hours after the first DEPTH_OF_DISCHARGE reading.
// - In interrupt mode the short flag drives the serial or enable pin.
// - Trip thresholds start from stored levels; host may rewrite both.
// - Trip function enabled by its bit; polarity from the polarity bit.
// - With trip function on, no other source reaches the serial pin.
// - Capacity is compared against set and clear levels continuously.
// - Set crossing during discharge sets trip flag and raises interrupt.
// - First clear crossing during charge flips the flag and interrupts.
// - Later clear crossings change nothing and keep any asserted level.
// - A threshold write clears the trip flag and releases the pin.
// - Without rewrites, crossings only update the flag, no new interrupt.
module gft_top
   import gft_pkg::*;
#(
   parameter logic [15:0] INIT_SET = INIT_SET_RESET,
   parameter logic [15:0] INIT_CLEAR = INIT_CLEAR_RESET,
   parameter int ADDR_W = 8
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire gft_gauge_t gauge,
   output logic shared_serial_pin_out,
   output logic shared_serial_pin_oe,
   output logic system_enable_pin
);
   generate
      if (ADDR_W < 8) begin : g_bad_addr
         $error("gft_top: ADDR_W must be at least 8");
      end
   endgenerate

   function automatic logic [5:0] word_index(input logic [ADDR_W-1:0] a);
      word_index = a[7:2];
   endfunction : word_index

   // Register state.
   logic [CTRL_W-1:0] ctrl_reg;
   logic [7:0] health_ratio_reg;
   logic [15:0] hour_rate_reg;
   logic [7:0] filter_reg;
   logic [7:0] wait_hours_reg;
   logic [15:0] trip_set_reg;
   logic [15:0] trip_clear_reg;
   logic tab_flag_reg;
   logic short_flag_reg;
   logic trip_flag_reg;
   logic trip_irq_reg;
   logic clear_done_reg;
   logic [7:0] prev_health_reg;
   logic prev_valid_reg;
   logic signed [15:0] sdc_reg;
   logic [7:0] hours_reg;
   logic isd_armed_reg;
   logic below_set_reg;
   logic above_clear_reg;
   logic wait_reg;
   logic [31:0] rdata_reg;
   logic ssp_out_reg;
   logic ssp_oe_reg;
   logic sep_reg;

   // Bus decode. A request is served on the cycle after it is first seen.
   wire [5:0] idx = word_index(avs_address);
   wire bus_req = avs_read | avs_write;
   wire wr_do = avs_write & ~wait_reg;
   wire rd_load = avs_read & wait_reg;
   wire wr_ctrl = wr_do & (idx == IDX_CTRL);
   wire wr_status = wr_do & (idx == IDX_STATUS);
   wire wr_set = wr_do & (idx == IDX_TRIP_SET);
   wire wr_clear = wr_do & (idx == IDX_TRIP_CLEAR);
   wire wr_ratio = wr_do & (idx == IDX_HEALTH_RATIO);
   wire wr_rate = wr_do & (idx == IDX_HOUR_RATE);
   wire wr_filter = wr_do & (idx == IDX_FILTER);
   wire wr_wait = wr_do & (idx == IDX_WAIT_HOURS);
   wire thr_write = wr_set | wr_clear;

   wire tab_en = ctrl_reg[CTRL_TAB_EN];
   wire short_en = ctrl_reg[CTRL_SHORT_EN];
   wire trip_en = ctrl_reg[CTRL_TRIP_EN];
   wire pol = ctrl_reg[CTRL_POL];
   wire int_mode = ctrl_reg[CTRL_INT_MODE];
   wire pin_sel = ctrl_reg[CTRL_PIN_SEL];

   wire [7:0] status_word = {3'h0, clear_done_reg, trip_irq_reg,
      trip_flag_reg, short_flag_reg, tab_flag_reg};

   logic [31:0] rdata_next;
   always_comb begin
      case (idx)
         IDX_CTRL: rdata_next = {26'h0, ctrl_reg};
         IDX_STATUS: rdata_next = {24'h0, status_word};
         IDX_TRIP_SET: rdata_next = {16'h0, trip_set_reg};
         IDX_TRIP_CLEAR: rdata_next = {16'h0, trip_clear_reg};
         IDX_SD_CURRENT: rdata_next = {16'h0, sdc_reg};
         IDX_HEALTH_RATIO: rdata_next = {24'h0, health_ratio_reg};
         IDX_HOUR_RATE: rdata_next = {16'h0, hour_rate_reg};
         IDX_FILTER: rdata_next = {24'h0, filter_reg};
         IDX_WAIT_HOURS: rdata_next = {24'h0, wait_hours_reg};
         default: rdata_next = 32'h0;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wait_reg <= 1'b1;
         rdata_reg <= 32'h0;
      end else begin
         wait_reg <= ~(bus_req & wait_reg);
         if (rd_load) begin
            rdata_reg <= rdata_next;
         end
      end
   end

   // Configuration registers; thresholds load the stored levels at reset.
   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl_reg <= CTRL_RESET;
         health_ratio_reg <= HEALTH_RATIO_RESET;
         hour_rate_reg <= HOUR_RATE_RESET;
         filter_reg <= FILTER_RESET;
         wait_hours_reg <= WAIT_HOURS_RESET;
         trip_set_reg <= INIT_SET;
         trip_clear_reg <= INIT_CLEAR;
      end else begin
         if (wr_ctrl) ctrl_reg <= avs_writedata[CTRL_W-1:0];
         if (wr_ratio) health_ratio_reg <= avs_writedata[7:0];
         if (wr_rate) hour_rate_reg <= avs_writedata[15:0];
         if (wr_filter) filter_reg <= avs_writedata[7:0];
         if (wr_wait) wait_hours_reg <= avs_writedata[7:0];
         if (wr_set) trip_set_reg <= avs_writedata[15:0];
         if (wr_clear) trip_clear_reg <= avs_writedata[15:0];
      end
   end

   // Tab disconnect: cross-multiplied so no divider is needed.
   wire [15:0] cur_scaled = 16'(gauge.health_estimate * PCT_SCALE);
   wire [15:0] prev_scaled = 16'(health_ratio_reg * prev_health_reg);
   wire tab_event = gauge.health_valid & tab_en & prev_valid_reg
      & (cur_scaled < prev_scaled);
   wire tab_clr = wr_status & avs_writedata[ST_TAB];

   always_ff @(posedge clock) begin
      if (rst) begin
         prev_health_reg <= 8'h00;
         prev_valid_reg <= 1'b0;
         tab_flag_reg <= 1'b0;
      end else begin
         if (gauge.health_valid) begin
            prev_health_reg <= gauge.health_estimate;
            prev_valid_reg <= 1'b1;
         end
         // A detection in the clearing cycle wins over the clear.
         tab_flag_reg <= tab_event | (tab_flag_reg & ~tab_clr);
      end
   end

   // Self-discharge filter: a larger setting gives a smaller step.
   wire [8:0] gain = FILTER_SPAN - {1'b0, filter_reg};
   wire signed [16:0] diff = 17'(gauge.sd_reading - sdc_reg);
   wire signed [26:0] prod = diff * $signed({1'b0, gain});
   wire signed [26:0] step = prod >>> FILTER_SHIFT;
   wire signed [17:0] sum = 18'(sdc_reg + step[16:0]);
   wire signed [15:0] sdc_next = sum[15:0];
   wire hour_eval = gauge.hour_tick & short_en & gauge.relax;
   wire signed [32:0] sdc_times_rate = sdc_next * $signed({1'b0,
      hour_rate_reg});
   wire signed [33:0] margin = 34'(sdc_times_rate + $signed({18'h0,
      gauge.design_capacity}));
   wire waited = isd_armed_reg & (hours_reg >= wait_hours_reg);
   wire short_event = hour_eval & waited & margin[33];
   wire short_clr = wr_status & avs_writedata[ST_SHORT];

   always_ff @(posedge clock) begin
      if (rst) begin
         sdc_reg <= 16'sh0000;
         hours_reg <= 8'h00;
         isd_armed_reg <= 1'b0;
         short_flag_reg <= 1'b0;
      end else begin
         if (hour_eval) sdc_reg <= sdc_next;
         // Leaving relaxation or disabling drops the wait; it restarts
         // from the next first depth-of-discharge reading.
         if (~gauge.relax | ~short_en) begin
            isd_armed_reg <= 1'b0;
            hours_reg <= 8'h00;
         end else if (gauge.dod_first) begin
            isd_armed_reg <= 1'b1;
            hours_reg <= 8'h00;
         end else if (hour_eval & isd_armed_reg & (hours_reg != 8'hff)) begin
            hours_reg <= 8'(hours_reg + 8'h01);
         end
         short_flag_reg <= short_event | (short_flag_reg & ~short_clr);
      end
   end

   // Capacity trip point: crossings are edges of the level compares.
   wire below_set = gauge.remaining_capacity_c < trip_set_reg;
   wire above_clear = gauge.remaining_capacity_c > trip_clear_reg;
   wire dischg = gauge.average_current_b < 16'sh0000;
   wire chg = gauge.average_current_b > 16'sh0000;
   wire set_event = trip_en & below_set & ~below_set_reg & dischg;
   wire clear_event = trip_en & above_clear & ~above_clear_reg & chg
      & ~clear_done_reg;
   wire trip_event = set_event | clear_event;

   always_ff @(posedge clock) begin
      if (rst) begin
         below_set_reg <= 1'b0;
         above_clear_reg <= 1'b0;
         trip_flag_reg <= 1'b0;
         trip_irq_reg <= 1'b0;
         clear_done_reg <= 1'b0;
      end else begin
         below_set_reg <= below_set;
         above_clear_reg <= above_clear;
         if (thr_write) begin
            trip_flag_reg <= 1'b0;
            trip_irq_reg <= 1'b0;
            clear_done_reg <= 1'b0;
         end else begin
            if (set_event) begin
               trip_flag_reg <= 1'b1;
            end else if (clear_event) begin
               trip_flag_reg <= ~trip_flag_reg;
               clear_done_reg <= 1'b1;
            end
            // A level that is already up stays up; no second edge.
            if (trip_event) trip_irq_reg <= 1'b1;
         end
      end
   end

   // Pin drive. Inactive level is the inverse of the active one.
   wire fault_any = tab_flag_reg | short_flag_reg;
   wire fault_irq = int_mode & fault_any;
   wire ssp_irq = trip_en ? trip_irq_reg : (fault_irq & ~pin_sel);
   wire sep_irq = fault_irq & pin_sel;

   always_ff @(posedge clock) begin
      if (rst) begin
         ssp_out_reg <= 1'b1;
         ssp_oe_reg <= 1'b0;
         sep_reg <= 1'b1;
      end else begin
         ssp_out_reg <= pol ? ssp_irq : ~ssp_irq;
         ssp_oe_reg <= trip_en | (int_mode & ~pin_sel);
         sep_reg <= pol ? sep_irq : ~sep_irq;
      end
   end

   assign avs_readdata = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign shared_serial_pin_out = ssp_out_reg;
   assign shared_serial_pin_oe = ssp_oe_reg;
   assign system_enable_pin = sep_reg;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   tab_ratio_set_a: assert property (
      gauge.health_valid && tab_en && prev_valid_reg
      && (cur_scaled < prev_scaled) |=> tab_flag_reg)
      else $error("tab flag missed a low health ratio");

   tab_gate_a: assert property (
      $rose(tab_flag_reg) |-> $past(tab_en))
      else $error("tab flag set while detection disabled");

   short_gate_a: assert property (
      $rose(short_flag_reg) |-> $past(short_en) && $past(gauge.hour_tick))
      else $error("short flag set outside an enabled hourly check");

   sdc_hourly_a: assert property (
      sdc_reg != $past(sdc_reg) |-> $past(gauge.hour_tick))
      else $error("filtered current changed without an hour tick");

   short_wait_a: assert property (
      $rose(short_flag_reg) |-> $past(hours_reg >= wait_hours_reg))
      else $error("short compare before the wait elapsed");

   trip_set_a: assert property (
      set_event && !thr_write |=> trip_flag_reg && trip_irq_reg)
      else $error("set crossing did not raise flag and interrupt");

   clear_once_a: assert property (
      clear_done_reg && !thr_write |=> trip_flag_reg == $past(trip_flag_reg)
      || $past(set_event))
      else $error("second clear crossing changed the trip flag");

   thr_reset_a: assert property (
      thr_write |=> !trip_flag_reg && !trip_irq_reg
      ##1 (ssp_out_reg == !pol || ssp_irq))
      else $error("threshold write did not release the trip state");

   trip_only_a: assert property (
      trip_en && !trip_irq_reg |=> ssp_out_reg == !$past(pol))
      else $error("other source reached the serial pin in trip mode");

   pin_level_a: assert property (
      ##1 sep_reg == ($past(pol) ~^ $past(sep_irq)))
      else $error("enable pin level disagrees with polarity");

   bus_wait_a: assert property (
      bus_req && wait_reg |=> !wait_reg ##1 wait_reg)
      else $error("bus answer not one wait state");

   tab_seen_c: cover property (tab_event);
   short_seen_c: cover property (short_event);
   trip_irq_c: cover property (set_event ##[1:100] thr_write);
   clear_flip_c: cover property (set_event ##[1:100] clear_event);
endmodule : gft_top
`default_nettype wire

// ===== hdl/gft_pkg.sv
`default_nettype none
package gft_pkg;
   // Word index of each register; the byte address is four times the index.
   localparam logic [5:0] IDX_CTRL = 6'h00;
   localparam logic [5:0] IDX_STATUS = 6'h01;
   localparam logic [5:0] IDX_TRIP_SET = 6'h02;
   localparam logic [5:0] IDX_TRIP_CLEAR = 6'h03;
   localparam logic [5:0] IDX_SD_CURRENT = 6'h04;
   localparam logic [5:0] IDX_HEALTH_RATIO = 6'h12;
   localparam logic [5:0] IDX_HOUR_RATE = 6'h13;
   localparam logic [5:0] IDX_FILTER = 6'h15;
   localparam logic [5:0] IDX_WAIT_HOURS = 6'h16;

   // Control register bit positions.
   localparam int CTRL_TAB_EN = 0;
   localparam int CTRL_SHORT_EN = 1;
   localparam int CTRL_TRIP_EN = 2;
   localparam int CTRL_POL = 3;
   localparam int CTRL_INT_MODE = 4;
   localparam int CTRL_PIN_SEL = 5;
   localparam int CTRL_W = 6;

   // Status register bit positions.
   localparam int ST_TAB = 0;
   localparam int ST_SHORT = 1;
   localparam int ST_TRIP = 2;
   localparam int ST_TRIP_IRQ = 3;
   localparam int ST_CLEAR_DONE = 4;

   // Reset values.
   localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
   localparam logic [7:0] HEALTH_RATIO_RESET = 8'h50;
   localparam logic [15:0] HOUR_RATE_RESET = 16'h000a;
   localparam logic [7:0] FILTER_RESET = 8'h7f;
   localparam logic [7:0] WAIT_HOURS_RESET = 8'h07;
   localparam logic [15:0] INIT_SET_RESET = 16'h0096;
   localparam logic [15:0] INIT_CLEAR_RESET = 16'h00af;

   // Ratio scale and filter gain span.
   localparam logic [7:0] PCT_SCALE = 8'h64;
   localparam logic [8:0] FILTER_SPAN = 9'h100;
   localparam int FILTER_SHIFT = 8;

   // Values delivered by the gauging core, all on the block's clock.
   typedef struct packed {
      logic health_valid;
      logic [7:0] health_estimate;
      logic hour_tick;
      logic dod_first;
      logic relax;
      logic signed [15:0] sd_reading;
      logic signed [15:0] average_current_b;
      logic [15:0] remaining_capacity_c;
      logic [15:0] design_capacity;
   } gft_gauge_t;
endpackage : gft_pkg
`default_nettype wire

// ===== tb/gft_host_model.sv
`default_nettype none
module gft_host_model (
   input wire logic clock,
   output logic [7:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   input wire logic avs_waitrequest
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
   end
   // The request stands until an edge sees waitrequest low, then drops.
   // Only the bench watchdog may end a wait that never gets an answer.
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do begin
         @(posedge clock);
      end while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : xfer
endmodule : gft_host_model
`default_nettype wire

// ===== tb/tb_top.sv
`default_nettype none
module tb_top;
   import gft_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [7:0] avs_address;
   logic avs_read, avs_write, avs_waitrequest;
   logic [31:0] avs_writedata, avs_readdata;
   logic ser_out, ser_oe, sys_pin;
   gft_gauge_t g = '0;
   int err_total = 0;
   int samples_checked = 0;
   logic [31:0] rd_q[$];
   logic [31:0] v;
   always #2 clock = ~clock;
   gft_top gft_top_inst (.clock(clock), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .gauge(g),
      .shared_serial_pin_out(ser_out), .shared_serial_pin_oe(ser_oe),
      .system_enable_pin(sys_pin));
   gft_host_model gft_host_model_inst (.clock(clock),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_waitrequest(avs_waitrequest));
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] s);
      samples_checked++;
      if (s !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // Read data is judged at the completing edge, oldest note first.
   always @(posedge clock) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         if (rd_q.size() == 0) chk("unexpected read", 32'h0, 32'h1);
         else chk("readdata", rd_q.pop_front(), avs_readdata);
      end
   end
   task automatic wr(input logic [5:0] i, input logic [31:0] d);
      gft_host_model_inst.xfer(1'b1, {i, 2'b00}, d);
   endtask : wr
   task automatic rd(input logic [5:0] i, input logic [31:0] e);
      rd_q.push_back(e);
      gft_host_model_inst.xfer(1'b0, {i, 2'b00}, 32'h0);
   endtask : rd
   task automatic pins(input logic s, input logic y);
      repeat (3) @(posedge clock);
      chk("serial pin", {31'h0, s}, {31'h0, ser_out});
      chk("enable pin", {31'h0, y}, {31'h0, sys_pin});
   endtask : pins
   task automatic hv(input logic [7:0] h);
      @(posedge clock);
      g.health_valid <= 1'b1;
      g.health_estimate <= h;
      @(posedge clock);
      g.health_valid <= 1'b0;
      repeat (3) @(posedge clock);
   endtask : hv
   task automatic tick(input logic [15:0] r);
      @(posedge clock);
      g.hour_tick <= 1'b1;
      g.sd_reading <= r;
      @(posedge clock);
      g.hour_tick <= 1'b0;
      repeat (3) @(posedge clock);
   endtask : tick
   task automatic cap(input logic [15:0] c, input logic [15:0] i);
      @(posedge clock);
      g.remaining_capacity_c <= c;
      g.average_current_b <= i;
      repeat (4) @(posedge clock);
   endtask : cap
   task automatic close_out;
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out
   initial begin
      #(4 * 30000);
      err_total++;
      close_out();
   end
   initial begin
      v = $urandom(40100);
      g.design_capacity = 16'h03e8;
      g.remaining_capacity_c = 16'h00c8;
      g.average_current_b = 16'hffce;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      chk("serial oe", 32'h0, {31'h0, ser_oe});
      pins(1'b1, 1'b1);
      rd(IDX_CTRL, 32'h0);
      rd(IDX_STATUS, 32'h0);
      rd(IDX_TRIP_SET, 32'h96);
      rd(IDX_TRIP_CLEAR, 32'haf);
      rd(IDX_HEALTH_RATIO, 32'h50);
      rd(IDX_HOUR_RATE, 32'ha);
      rd(IDX_FILTER, 32'h7f);
      rd(IDX_WAIT_HOURS, 32'h7);
      rd(6'h2c, 32'h0);
      $display("test reset done");
      // Detection off: a steep drop must leave the flag clear.
      wr(IDX_CTRL, 32'h10);
      hv(8'h64);
      hv(8'h32);
      rd(IDX_STATUS, 32'h0);
      wr(IDX_CTRL, 32'h11);
      hv(8'h64);
      hv(8'h50);
      rd(IDX_STATUS, 32'h0);
      hv(8'h3f);
      rd(IDX_STATUS, 32'h1);
      pins(1'b0, 1'b1);
      wr(IDX_CTRL, 32'h31);
      pins(1'b1, 1'b0);
      chk("serial oe", 32'h0, {31'h0, ser_oe});
      $display("test tab done");
      wr(IDX_FILTER, 32'h0);
      wr(IDX_WAIT_HOURS, 32'h2);
      wr(IDX_CTRL, 32'h13);
      @(posedge clock);
      g.relax <= 1'b1;
      g.dod_first <= 1'b1;
      @(posedge clock);
      g.dod_first <= 1'b0;
      tick(16'hff38);
      rd(IDX_STATUS, 32'h1);
      tick(16'hff38);
      tick(16'hff38);
      rd(IDX_STATUS, 32'h3);
      rd(IDX_SD_CURRENT, 32'hff38);
      wr(IDX_FILTER, 32'h80);
      tick(16'h0);
      rd(IDX_SD_CURRENT, 32'hff9c);
      wr(IDX_STATUS, 32'h2);
      g.relax <= 1'b0;
      rd(IDX_STATUS, 32'h1);
      $display("test short done");
      // The tab flag stays set so that its pin drive must be masked.
      wr(IDX_CTRL, 32'h1d);
      wr(IDX_TRIP_SET, 32'h64);
      wr(IDX_TRIP_CLEAR, 32'h78);
      rd(IDX_STATUS, 32'h1);
      pins(1'b0, 1'b0);
      chk("serial oe", 32'h1, {31'h0, ser_oe});
      cap(16'h005a, 16'hffce);
      rd(IDX_STATUS, 32'hd);
      pins(1'b1, 1'b0);
      cap(16'h0082, 16'h0032);
      rd(IDX_STATUS, 32'h19);
      cap(16'h005a, 16'hffce);
      rd(IDX_STATUS, 32'h1d);
      cap(16'h0082, 16'h0032);
      rd(IDX_STATUS, 32'h1d);
      pins(1'b1, 1'b0);
      wr(IDX_TRIP_SET, 32'h64);
      rd(IDX_STATUS, 32'h1);
      pins(1'b0, 1'b0);
      cap(16'h005a, 16'h0032);
      rd(IDX_STATUS, 32'h1);
      cap(16'h006e, 16'hffce);
      cap(16'h005a, 16'hffce);
      rd(IDX_STATUS, 32'hd);
      rd(IDX_TRIP_SET, 32'h64);
      $display("test trip done");
      v = $urandom % 101;
      wr(IDX_HEALTH_RATIO, v);
      wr(6'h2c, 32'hffff_ffff);
      rd(IDX_HEALTH_RATIO, {24'h0, v[7:0]});
      rd(6'h2c, 32'h0);
      $display("test registers done");
      close_out();
   end
endmodule : tb_top
`default_nettype wire
